//--- design/rcs_defs.svh
// Constants for the reset control sequencer: APB offsets, reset values, counts.
// Assumes an 8-bit byte address on APB and 32-bit data.
//
// What this block does
// - Five sources feed internal reset: pin, power-on, brown-out, software, watchdog.
// - Each reset sets its cause bit; cause bits survive later resets.
// - Power-on reset clears all cause bits except power-on, which it sets.
// - Pin reset resets core and peripherals, not the test access port.
// - After the pin releases, a few synchronizing cycles pass before release.
// - After release the core fetches stack pointer, program counter, first instruction.
// - At power-up, release follows the later of pin and power-on going inactive.
// - Power-on reset only acts on the initial power-up.
// - Power-on reset also resets the test access port; pin reset does not.
// - Brown-out detection is off after reset until software enables it.
// - A brown-out raises an interrupt or a reset, as configured.
// - Brown-out resets only when the brown-out reset enable bit is set.
// - Brown-out reset acts like pin reset, held while brown-out persists.
// - Three peripheral soft reset registers; setting then clearing a bit resets it.
// - Soft reset bit positions match the clock gating register positions.
// - A peripheral soft reset asserts the unit's resets in all its domains.
// - The system reset request bit resets the whole system, then normal fetch.
// - Watchdog: interrupt on first time-out, reset request on second.
// - After first time-out the 32-bit counter reloads from the load register.
// - Watchdog resets only on zero with interrupt uncleared and reset enabled.
// - Regulator adjust field selects 2.25 V to 2.75 V in small steps.
// - Read-only identification registers report version, part, memory, features.
`ifndef RCS_DEFS_SVH
`define RCS_DEFS_SVH

`define RCS_A_ID0 8'h00
`define RCS_A_ID1 8'h04
`define RCS_A_CAP0 8'h08
`define RCS_A_CAP4 8'h18
`define RCS_A_PBOR 8'h1c
`define RCS_A_CAUSE 8'h20
`define RCS_A_REG 8'h24
`define RCS_A_SRC0 8'h28
`define RCS_A_SRC1 8'h2c
`define RCS_A_SRC2 8'h30
`define RCS_A_WLOAD 8'h34
`define RCS_A_WCTL 8'h38
`define RCS_A_WCLR 8'h3c
`define RCS_A_STAT 8'h40
`define RCS_A_WVAL 8'h44

`define RCS_RELEASE_CYCLES 3'h4
`define RCS_WLOAD_RST 32'hffffffff
`define RCS_ADJ_RST 5'h05
`define RCS_ADJ_MAX 5'h0a
`define RCS_CAUSE_POR 5'h02

`endif

//--- design/rcs_pkg.sv
// Types shared by the reset control sequencer.
// Assumes nothing beyond a SystemVerilog tool.
package rcs_pkg;

    // Reset cause bits, pin at bit 0
    typedef struct packed {
        logic wdt;
        logic sw;
        logic brown;
        logic por;
        logic ext;
    } rcs_cause_t;

    typedef struct packed {
        logic resetEn;
        logic detectEn;
    } rcs_pbor_t;

    typedef struct packed {
        logic resetEn;
        logic run;
    } rcs_wctl_t;

    typedef enum logic [2:0] {
        FETCH_HOLD = 3'b000,
        FETCH_SP = 3'b001,
        FETCH_PC = 3'b010,
        FETCH_INSTR = 3'b011,
        FETCH_RUN = 3'b100
    } rcs_fetch_t;

endpackage : rcs_pkg

//--- design/rcs_reset_control_sequencer.sv
// Reset control sequencer: merges reset sources, records cause, sequences release.
// Assumes APB master on clk; supply detectors and reset pin synchronous to clk.
`timescale 1ns/1ps
`include "rcs_defs.svh"

module rcs_reset_control_sequencer #(
    parameter int PERIPH_W = 32,
    // Identification words, arbitrary neutral values
    parameter logic [6:0][31:0] IDENT = {7{32'h0000_1001}}
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rstPinN,
    input wire logic porDetect,
    input wire logic brownoutDetect,
    input wire logic systemResetRequestBit,
    input wire logic coreFetchAck,
    output logic internalRst,
    output logic tapRst,
    output logic [2:0][PERIPH_W-1:0] periphRst,
    output logic brownoutIrq,
    output logic watchdogIrq,
    output logic [4:0] regulatorVoltageAdjust,
    output rcs_pkg::rcs_fetch_t coreFetchStage
);

    if (PERIPH_W < 1 || PERIPH_W > 32) begin : g_check
        $error("PERIPH_W must be 1 to 32");
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave, one wait state

    logic accStart;
    logic accDone;
    logic wrDone;
    logic hit;
    logic [31:0] rdMux;
    logic pready_q;

    assign accStart = psel & penable & ~pready_q;
    assign accDone = psel & penable & pready_q;
    assign wrDone = accDone & pwrite;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pready_q <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready_q <= accStart;
            pslverr <= accStart & ~hit;
            prdata <= (accStart & ~pwrite) ? rdMux : 32'h0;
        end
    end

    assign pready = pready_q;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronizer and sources

    logic pinMeta_q;
    logic pinSync_q;
    logic porArmed_q;
    logic porActive;
    logic extActive;
    logic brownRstReq;
    logic wdtRst_q;
    logic anySrc;
    rcs_pkg::rcs_pbor_t pbor_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pinMeta_q <= 1'b1; // Idle pin level, so no false pin cause after reset
            pinSync_q <= 1'b1;
        end else begin
            pinMeta_q <= rstPinN;
            pinSync_q <= pinMeta_q;
        end
    end

    assign extActive = ~pinSync_q;
    assign porActive = porDetect & porArmed_q;
    assign brownRstReq = brownoutDetect & pbor_q.detectEn & pbor_q.resetEn;
    assign anySrc = extActive | porActive | brownRstReq
        | systemResetRequestBit | wdtRst_q;

    ////////////////////////////////////////////////////////////////////////////
    // Internal reset and release count

    logic [2:0] holdCnt_q;

    // Assertion is one clock late: the output must come from a flop
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            internalRst <= 1'b1;
            holdCnt_q <= `RCS_RELEASE_CYCLES;
        end else if (anySrc) begin
            internalRst <= 1'b1;
            holdCnt_q <= `RCS_RELEASE_CYCLES;
        end else if (holdCnt_q != 3'h0) begin
            holdCnt_q <= holdCnt_q - 3'h1;
        end else begin
            internalRst <= 1'b0;
        end
    end

    // Power-on detector is honoured only until the first release
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            porArmed_q <= 1'b1;
        end else if (!internalRst) begin
            porArmed_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tapRst <= 1'b1;
        end else begin
            tapRst <= porActive | (tapRst & internalRst);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset cause

    rcs_pkg::rcs_cause_t cause_q;
    rcs_pkg::rcs_cause_t causeSet;
    rcs_pkg::rcs_cause_t causeClr;

    assign causeSet = '{wdt: wdtRst_q, sw: systemResetRequestBit, brown: brownRstReq,
                        por: porActive, ext: extActive};
    assign causeClr = (wrDone && paddr == `RCS_A_CAUSE) ? pwdata[4:0] : 5'h0;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cause_q <= `RCS_CAUSE_POR;
        end else if (porActive) begin
            cause_q <= `RCS_CAUSE_POR;
        end else begin
            cause_q <= (cause_q & ~causeClr) | causeSet;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Brown-out control and interrupt flag

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pbor_q <= '0;
        end else if (wrDone && paddr == `RCS_A_PBOR) begin
            pbor_q <= pwdata[1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            brownoutIrq <= 1'b0;
        end else if (brownoutDetect & pbor_q.detectEn & ~pbor_q.resetEn) begin
            brownoutIrq <= 1'b1;
        end else if (wrDone && paddr == `RCS_A_STAT && pwdata[0]) begin
            brownoutIrq <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Peripheral soft resets, bit n matches clock gate bit n

    logic [2:0][PERIPH_W-1:0] soft_q;

    for (genvar i = 0; i < 3; i++) begin : g_soft
        logic [7:0] regAddr;
        assign regAddr = `RCS_A_SRC0 + 8'(4 * i);
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                soft_q[i] <= '0;
                periphRst[i] <= '1;
            end else begin
                if (wrDone && paddr == regAddr) begin
                    soft_q[i] <= pwdata[PERIPH_W-1:0];
                end
                // One line per unit covers all of its clock domains
                periphRst[i] <= soft_q[i] | {PERIPH_W{internalRst}};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog

    logic [31:0] wLoad_q;
    logic [31:0] wCnt_q;
    rcs_pkg::rcs_wctl_t wCtl_q;
    logic wTimeout;

    assign wTimeout = wCtl_q.run && wCnt_q == 32'h0;

    always_ff @(posedge clk) begin
        if (sys_rst || internalRst) begin
            wLoad_q <= `RCS_WLOAD_RST;
            wCtl_q <= '0;
        end else begin
            if (wrDone && paddr == `RCS_A_WLOAD) begin
                wLoad_q <= pwdata;
            end
            if (wrDone && paddr == `RCS_A_WCTL) begin
                wCtl_q <= pwdata[1:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || internalRst) begin
            wCnt_q <= `RCS_WLOAD_RST;
        end else if (wrDone && paddr == `RCS_A_WLOAD) begin
            wCnt_q <= pwdata;
        end else if (!wCtl_q.run || wTimeout) begin
            wCnt_q <= wLoad_q;
        end else begin
            wCnt_q <= wCnt_q - 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || internalRst) begin
            watchdogIrq <= 1'b0;
            wdtRst_q <= 1'b0;
        end else begin
            wdtRst_q <= wTimeout & watchdogIrq & wCtl_q.resetEn;
            if (wTimeout) begin
                watchdogIrq <= 1'b1;
            end else if (wrDone && paddr == `RCS_A_WCLR) begin
                watchdogIrq <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Regulator adjust: 2.25 V + 50 mV per code, codes 0 to 10

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            regulatorVoltageAdjust <= `RCS_ADJ_RST;
        end else if (wrDone && paddr == `RCS_A_REG && pwdata[4:0] <= `RCS_ADJ_MAX) begin
            regulatorVoltageAdjust <= pwdata[4:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fetch sequence after release

    always_ff @(posedge clk) begin
        if (sys_rst || internalRst) begin
            coreFetchStage <= rcs_pkg::FETCH_HOLD;
        end else begin
            unique case (coreFetchStage)
                rcs_pkg::FETCH_HOLD: coreFetchStage <= rcs_pkg::FETCH_SP;
                rcs_pkg::FETCH_SP: if (coreFetchAck) coreFetchStage <= rcs_pkg::FETCH_PC;
                rcs_pkg::FETCH_PC: if (coreFetchAck) coreFetchStage <= rcs_pkg::FETCH_INSTR;
                rcs_pkg::FETCH_INSTR: if (coreFetchAck) coreFetchStage <= rcs_pkg::FETCH_RUN;
                rcs_pkg::FETCH_RUN: coreFetchStage <= rcs_pkg::FETCH_RUN;
                default: coreFetchStage <= rcs_pkg::FETCH_HOLD;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux

    always_comb begin
        hit = 1'b1;
        rdMux = 32'h0;
        unique case (paddr)
            `RCS_A_ID0: rdMux = IDENT[0];
            `RCS_A_ID1: rdMux = IDENT[1];
            8'h08, 8'h0c, 8'h10, 8'h14, `RCS_A_CAP4: rdMux = IDENT[3'(paddr[4:2])];
            `RCS_A_PBOR: rdMux = {30'h0, pbor_q};
            `RCS_A_CAUSE: rdMux = {27'h0, cause_q};
            `RCS_A_REG: rdMux = {27'h0, regulatorVoltageAdjust};
            `RCS_A_SRC0: rdMux = 32'(soft_q[0]);
            `RCS_A_SRC1: rdMux = 32'(soft_q[1]);
            `RCS_A_SRC2: rdMux = 32'(soft_q[2]);
            `RCS_A_WLOAD: rdMux = wLoad_q;
            `RCS_A_WCTL: rdMux = {30'h0, wCtl_q};
            `RCS_A_WCLR: rdMux = {31'h0, watchdogIrq};
            `RCS_A_STAT: rdMux = {27'h0, coreFetchStage, tapRst, brownoutIrq};
            `RCS_A_WVAL: rdMux = wCnt_q;
            default: hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_src;
        anySrc;
    endsequence

    sequence s_quiet;
        !anySrc [*5];
    endsequence

    property p_pin_sync;
        !rstPinN |-> ##3 internalRst;
    endproperty
    a_pin_sync: assert property (p_pin_sync) else $error("pin reset not applied");

    property p_hold;
        s_src |=> internalRst [*5];
    endproperty
    a_hold: assert property (p_hold) else $error("reset released early");

    property p_release;
        s_src ##1 s_quiet |=> !internalRst;
    endproperty
    a_release: assert property (p_release) else $error("reset not released");

    property p_por_cause;
        porActive |=> cause_q == `RCS_CAUSE_POR;
    endproperty
    a_por_cause: assert property (p_por_cause) else $error("bad power-on cause");

    // Power-on wins the cause register, so it is left out here
    property p_brown;
        brownRstReq && !porActive |=> internalRst && cause_q.brown;
    endproperty
    a_brown: assert property (p_brown) else $error("brown-out reset missed");

    property p_brown_off;
        !pbor_q.detectEn && !brownoutIrq |=> !brownoutIrq;
    endproperty
    a_brown_off: assert property (p_brown_off) else $error("brown-out while off");

    property p_brown_irq;
        brownoutDetect && pbor_q.detectEn && !pbor_q.resetEn |=> brownoutIrq;
    endproperty
    a_brown_irq: assert property (p_brown_irq) else $error("brown-out flag missed");

    property p_cause_keep;
        !porActive && cause_q.ext && !causeClr.ext |=> cause_q.ext;
    endproperty
    a_cause_keep: assert property (p_cause_keep) else $error("cause bit lost");

    property p_periph_rst;
        internalRst |=> &periphRst;
    endproperty
    a_periph_rst: assert property (p_periph_rst) else $error("unit reset missed");

    property p_adj_refuse;
        wrDone && paddr == `RCS_A_REG && pwdata[4:0] > `RCS_ADJ_MAX
            |=> $stable(regulatorVoltageAdjust);
    endproperty
    a_adj_refuse: assert property (p_adj_refuse) else $error("bad code taken");

    property p_tap;
        !porActive && !tapRst |=> !tapRst;
    endproperty
    a_tap: assert property (p_tap) else $error("test port reset by pin");

    property p_fetch;
        coreFetchStage == rcs_pkg::FETCH_SP && coreFetchAck && !internalRst
            |=> coreFetchStage == rcs_pkg::FETCH_PC;
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch order broken");

    property p_wdt_rst;
        wTimeout && watchdogIrq && wCtl_q.resetEn && !internalRst
            |=> wdtRst_q ##1 internalRst;
    endproperty
    a_wdt_rst: assert property (p_wdt_rst) else $error("watchdog reset missed");

    property p_wdt_reload;
        wTimeout && !internalRst && !wrDone |=> wCnt_q == $past(wLoad_q);
    endproperty
    a_wdt_reload: assert property (p_wdt_reload) else $error("watchdog no reload");

endmodule : rcs_reset_control_sequencer

//--- verification/rcs_far_side.sv
// Far-side model: reset pin driver with pull-up, power-on and brown-out detectors.
// Assumes the bench commands each source; every output changes just after clk.
`timescale 1ns/1ps

module rcs_far_side (
    input wire logic clk,
    input wire logic pinLow,
    input wire logic porOn,
    input wire logic borOn,
    output logic rstPinN = 1'b1,
    output logic porDetect = 1'b1,
    output logic brownoutDetect = 1'b0
);
    // A released pin returns to its pull-up level, never holds the old drive
    always_ff @(posedge clk) begin
        rstPinN <= !pinLow;
    end

    // Detectors are plain levels; the power-on one pulses at power-up and once more later
    always_ff @(posedge clk) begin
        porDetect <= porOn;
        brownoutDetect <= borOn;
    end
endmodule : rcs_far_side

//--- verification/tb_reset_control_sequencer.sv
// Self-checking bench for the reset control sequencer over APB.
// Assumes rcs_far_side drives the pin and supply detectors.
`timescale 1ns/1ps
`include "rcs_defs.svh"

module tb_reset_control_sequencer;
    localparam logic [31:0] ID_WORD = 32'h0000_2002; // Arbitrary identification value
    logic clk = 1'b0;
    logic sysRst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdv, v;
    logic pready, pslverr, er, sysReq = 1'b0, fetchAck = 1'b0;
    logic pinLow = 1'b0, porOn = 1'b1, borOn = 1'b0;
    logic rstPinN, porDetect, brownoutDetect, internalRst, tapRst, brownoutIrq, watchdogIrq;
    logic [2:0][31:0] periphRst;
    logic [4:0] adjCode;
    rcs_pkg::rcs_fetch_t stage;
    int errCount = 0, nCompared = 0, n, causeM, adjM;

    always #2.5 clk = ~clk;

    rcs_far_side u_rcs_far_side (.clk(clk), .pinLow(pinLow), .porOn(porOn), .borOn(borOn),
        .rstPinN(rstPinN), .porDetect(porDetect), .brownoutDetect(brownoutDetect));

    rcs_reset_control_sequencer #(.PERIPH_W(32), .IDENT({7{ID_WORD}}))
    u_rcs_reset_control_sequencer (.clk(clk), .sys_rst(sysRst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rstPinN(rstPinN), .porDetect(porDetect),
        .brownoutDetect(brownoutDetect), .systemResetRequestBit(sysReq),
        .coreFetchAck(fetchAck), .internalRst(internalRst), .tapRst(tapRst),
        .periphRst(periphRst), .brownoutIrq(brownoutIrq), .watchdogIrq(watchdogIrq),
        .regulatorVoltageAdjust(adjCode), .coreFetchStage(stage));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic reportAndStop();
        if (errCount == 0 && nCompared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : reportAndStop

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        nCompared++;
        if (got !== exp) begin
            errCount++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Request held until pready is seen high; only then released
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // Only the bench watchdog ends this wait
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rdv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rdv);
    endtask : rd

    // Bounded wait on internal reset (0) or the watchdog flag (1)
    task automatic waitOn(input int which, input logic lvl, input int lim);
        n = 0;
        while ((which == 0 ? internalRst : watchdogIrq) !== lvl && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask : waitOn

    task automatic fetch();
        waitOn(0, 1'b0, 40);
        @(posedge clk);
        for (int s = 1; s < 4; s++) begin
            chk("fetch stage", s, stage);
            fetchAck <= 1'b1;
            @(posedge clk);
            fetchAck <= 1'b0;
            @(posedge clk);
        end
        chk("fetch stage", rcs_pkg::FETCH_RUN, stage);
    endtask : fetch

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        errCount++;
        reportAndStop();
    end

    initial begin
        v = $urandom(32'h5f0af947);
        repeat (6) @(posedge clk);
        sysRst <= 1'b0;
        repeat (8) @(posedge clk);
        chk("held by por", 2'b11, {internalRst, tapRst});
        porOn <= 1'b0;
        fetch();
        causeM = `RCS_CAUSE_POR;
        adjM = `RCS_ADJ_RST;
        rd(`RCS_A_CAUSE, causeM, "cause");
        rd(`RCS_A_PBOR, 0, "bor ctl");
        apb(1'b1, `RCS_A_ID1, ~ID_WORD);
        rd(`RCS_A_ID1, ID_WORD, "ident");
        apb(1'b0, 8'h48, 32'h0);
        chk("unmapped error", 1, er);
        chk("unmapped data", 0, rdv);
        apb(1'b1, `RCS_A_CAUSE, 32'h1f);
        causeM = 0;
        rd(`RCS_A_CAUSE, causeM, "cause clear");
        for (int i = 0; i < 3; i++) begin
            v = $urandom;
            apb(1'b1, 8'(`RCS_A_SRC0 + 4 * i), v);
            @(posedge clk);
            chk("periph set", v, periphRst[i]);
            apb(1'b1, 8'(`RCS_A_SRC0 + 4 * i), 32'h0);
            @(posedge clk);
            chk("periph clear", 0, periphRst[i]);
        end
        chk("adjust", adjM, adjCode);
        // Alternate legal and refused codes so both paths are hit
        for (int i = 0; i < 8; i++) begin
            v = i[0] ? $urandom_range(`RCS_ADJ_MAX) : $urandom_range(31, `RCS_ADJ_MAX + 1);
            apb(1'b1, `RCS_A_REG, v);
            if (v <= `RCS_ADJ_MAX) begin
                adjM = v;
            end
            @(posedge clk);
            chk("adjust", adjM, adjCode);
        end
        pinLow <= 1'b1;
        waitOn(0, 1'b1, 10);
        repeat (4) @(posedge clk);
        chk("pin rst tap", 2'b10, {internalRst, tapRst});
        pinLow <= 1'b0;
        waitOn(0, 1'b0, 40);
        chk("pin sync", 1, n > 3);
        fetch();
        causeM |= 1;
        rd(`RCS_A_CAUSE, causeM, "cause pin");
        sysReq <= 1'b1;
        @(posedge clk);
        sysReq <= 1'b0;
        waitOn(0, 1'b1, 5);
        chk("sw rst", 1, internalRst);
        fetch();
        causeM |= 8;
        rd(`RCS_A_CAUSE, causeM, "cause sw");
        borOn <= 1'b1;
        repeat (10) @(posedge clk);
        chk("bor off", 0, {brownoutIrq, internalRst});
        borOn <= 1'b0;
        apb(1'b1, `RCS_A_PBOR, 32'h1);
        borOn <= 1'b1;
        repeat (10) @(posedge clk);
        chk("bor irq", 2'b10, {brownoutIrq, internalRst});
        borOn <= 1'b0;
        apb(1'b1, `RCS_A_PBOR, 32'h3);
        borOn <= 1'b1;
        waitOn(0, 1'b1, 10);
        repeat (20) @(posedge clk);
        chk("bor held", 1, internalRst);
        borOn <= 1'b0;
        fetch();
        causeM |= 4;
        porOn <= 1'b1;
        repeat (10) @(posedge clk);
        chk("por once", 0, internalRst);
        porOn <= 1'b0;
        rd(`RCS_A_CAUSE, causeM, "cause bor");
        apb(1'b1, `RCS_A_STAT, 32'h1);
        chk("bor irq clear", 0, brownoutIrq);
        rd(`RCS_A_STAT, 32'h10, "status");
        apb(1'b1, `RCS_A_WLOAD, 32'd20);
        apb(1'b1, `RCS_A_WCTL, 32'h1);
        waitOn(1, 1'b1, 60);
        chk("wdt irq", 1, watchdogIrq);
        apb(1'b1, `RCS_A_WCLR, 32'h0);
        chk("wdt irq clear", 0, watchdogIrq);
        apb(1'b0, `RCS_A_WVAL, 32'h0);
        chk("wdt reload", 1, rdv <= 20);
        repeat (60) @(posedge clk);
        chk("wdt no rst", 0, internalRst);
        apb(1'b1, `RCS_A_WCTL, 32'h3);
        waitOn(0, 1'b1, 60);
        chk("wdt rst", 1, internalRst);
        fetch();
        causeM |= 16;
        rd(`RCS_A_CAUSE, causeM, "cause wdt");
        reportAndStop();
    end
endmodule : tb_reset_control_sequencer
